// ---- core/lhi_fifo.sv ----
`timescale 1ns/1ns
module lhi_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic out_valid_r;
  logic [W-1:0] out_data_r;

  wire logic push = in_valid && in_ready;
  wire logic pop = (cnt_r != '0) && (!out_valid_r || out_ready);
  wire logic [AW:0] cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);

  assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  // The array is written without reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
        out_data_r <= mem[rptr_r];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

endmodule : lhi_fifo

// ---- core/lhi_host_port.sv ----
`timescale 1ns/1ns
module lhi_host_port
  import lhi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chip_select_low_active_n,
  input wire logic chip_select_high_active,
  input wire logic data_command_select,
  input wire logic read_strobe_pin,
  input wire logic write_strobe_pin,
  input wire logic host_bus_style_select,
  input wire logic parallel_serial_select,
  input wire logic master_slave_select,
  input wire logic reset_in_n,
  input wire logic [BYTE_W-1:0] data_in,
  output logic [BYTE_W-1:0] data_out,
  output logic data_oe,
  input wire logic display_line_clock_in,
  output logic display_line_clock_out,
  output logic display_line_clock_oe,
  input wire logic lcd_ac_phase_in,
  output logic lcd_ac_phase_out,
  output logic lcd_ac_phase_oe,
  input wire logic display_blank_n_in,
  output logic display_blank_n_out,
  output logic display_blank_n_oe,
  output logic common_start_pulse_out,
  output logic common_start_pulse_oe,
  output logic static_drive_output_out,
  output logic static_drive_output_oe,
  input wire logic timing_line_clock,
  input wire logic timing_ac_phase,
  input wire logic timing_start_pulse,
  input wire logic timing_static_drive,
  input wire logic timing_blank_n,
  output logic line_clock_seen,
  output logic ac_phase_seen,
  output logic blank_n_seen,
  output logic osc_enable,
  output logic power_enable,
  output logic device_init,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_is_display,
  output logic read_req,
  output logic read_is_display,
  input wire logic [BYTE_W-1:0] read_display_data,
  input wire logic [BYTE_W-2:0] read_status,
  output logic host_busy
);

  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_r;
  logic [PIN_W-1:0] pin_prev_r;
  logic [BYTE_W-1:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic push_r;
  logic [WORD_W-1:0] push_word_r;
  logic [BYTE_W-1:0] data_out_r;
  logic data_oe_r;
  logic read_req_r;
  logic read_is_display_r;
  logic device_init_r;
  logic master_r;
  logic line_clock_out_r;
  logic ac_phase_out_r;
  logic blank_n_out_r;
  logic start_pulse_out_r;
  logic static_out_r;
  logic host_busy_r;
  logic fifo_in_ready;
  logic [WORD_W-1:0] fifo_out_word;

  wire logic [PIN_W-1:0] pin_raw = {data_in, display_blank_n_in, lcd_ac_phase_in, display_line_clock_in,
                                    reset_in_n, master_slave_select, parallel_serial_select,
                                    host_bus_style_select, write_strobe_pin, read_strobe_pin,
                                    data_command_select, chip_select_high_active, chip_select_low_active_n};

  // Two-stage synchroniser for every pin.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= PIN_RST_VAL;
      pin_r <= PIN_RST_VAL;
      pin_prev_r <= PIN_RST_VAL;
    end else begin
      pin_meta_r <= pin_raw;
      pin_r <= pin_meta_r;
      pin_prev_r <= pin_r;
    end
  end

  function automatic logic rose(input logic [PIN_W-1:0] now, input logic [PIN_W-1:0] prev, input int idx);
    rose = now[idx] && !prev[idx];
  endfunction : rose

  function automatic logic fell(input logic [PIN_W-1:0] now, input logic [PIN_W-1:0] prev, input int idx);
    fell = !now[idx] && prev[idx];
  endfunction : fell

  wire logic core_rst = sys_rst || !pin_r[PIN_RST_N];
  wire logic selected = !pin_r[PIN_CS_N] && pin_r[PIN_CS];
  wire logic [BYTE_W-1:0] bus_byte = pin_r[PIN_DATA +: BYTE_W];
  // Mode pin picks parallel or serial; style only in parallel.
  wire lhi_mode_e mode = !pin_r[PIN_PS] ? MODE_SERIAL : (pin_r[PIN_STYLE] ? MODE_6800 : MODE_8080);
  // Class bit from the select pin.
  wire logic is_display = pin_r[PIN_DC];

  wire logic ser_clk_rise = rose(pin_r, pin_prev_r, PIN_DATA + SER_CLK_BIT);
  wire logic ser_bit = pin_r[PIN_DATA + SER_DATA_BIT];
  wire logic ser_step = (mode == MODE_SERIAL) && selected && ser_clk_rise;
  wire logic ser_done = ser_step && (bit_cnt_r == BIT_CNT_LAST);

  // 8080 strobes are active low; write pin is a strobe.
  wire logic wr_8080 = (mode == MODE_8080) && selected && rose(pin_r, pin_prev_r, PIN_WR);
  wire logic rd_8080 = (mode == MODE_8080) && selected && fell(pin_r, pin_prev_r, PIN_RD);
  // Enable clock times the cycle; write pin is direction.
  wire logic wr_6800 = (mode == MODE_6800) && selected && !pin_r[PIN_WR] && fell(pin_r, pin_prev_r, PIN_RD);
  wire logic rd_6800 = (mode == MODE_6800) && selected && pin_r[PIN_WR] && rose(pin_r, pin_prev_r, PIN_RD);
  wire logic par_write = wr_8080 || wr_6800;
  wire logic par_read = rd_8080 || rd_6800;

  // Drive window per bus style; never in serial.
  wire logic drive_now = selected &&
                         (((mode == MODE_8080) && !pin_r[PIN_RD]) ||
                          ((mode == MODE_6800) && pin_r[PIN_RD] && pin_r[PIN_WR]));

  wire logic master_now = pin_r[PIN_MS];
  wire logic [BYTE_W-1:0] read_byte = is_display ? read_display_data : {host_busy_r, read_status};

  always_ff @(posedge clk) begin
    if (core_rst || !selected || (mode != MODE_SERIAL)) begin
      shift_r <= BYTE_RST;
      bit_cnt_r <= BIT_CNT_RST;
    end else if (ser_step) begin
      shift_r <= {shift_r[BYTE_W-2:0], ser_bit};
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  // Class sampled with the eighth bit.
  always_ff @(posedge clk) begin
    if (core_rst) begin
      push_r <= 1'b0;
      push_word_r <= '0;
    end else begin
      push_r <= ser_done || par_write;
      if (ser_done) begin
        push_word_r <= {is_display, shift_r[BYTE_W-2:0], ser_bit};
      end else if (par_write) begin
        push_word_r <= {is_display, bus_byte};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_out_r <= BYTE_RST;
      data_oe_r <= 1'b0;
      read_req_r <= 1'b0;
      read_is_display_r <= 1'b0;
    end else begin
      data_oe_r <= drive_now;
      read_req_r <= par_read;
      if (par_read) begin
        data_out_r <= read_byte;
        read_is_display_r <= is_display;
      end
    end
  end

  // Role controls pins, oscillator and power.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_init_r <= 1'b1;
      master_r <= 1'b0;
      line_clock_out_r <= 1'b0;
      ac_phase_out_r <= 1'b0;
      blank_n_out_r <= 1'b0;
      start_pulse_out_r <= 1'b0;
      static_out_r <= 1'b0;
      host_busy_r <= 1'b0;
    end else begin
      device_init_r <= !pin_r[PIN_RST_N];
      master_r <= master_now;
      line_clock_out_r <= timing_line_clock;
      ac_phase_out_r <= timing_ac_phase;
      blank_n_out_r <= timing_blank_n;
      start_pulse_out_r <= timing_start_pulse;
      static_out_r <= timing_static_drive;
      host_busy_r <= !fifo_in_ready;
    end
  end

  lhi_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(core_rst),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(push_word_r),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(fifo_out_word)
  );

  assign rx_data = fifo_out_word[BYTE_W-1:0];
  assign rx_is_display = fifo_out_word[WORD_CLASS_BIT];
  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign read_req = read_req_r;
  assign read_is_display = read_is_display_r;
  assign device_init = device_init_r;
  assign host_busy = host_busy_r;
  assign osc_enable = master_r;
  assign power_enable = master_r;
  assign display_line_clock_out = line_clock_out_r;
  assign display_line_clock_oe = master_r;
  assign lcd_ac_phase_out = ac_phase_out_r;
  assign lcd_ac_phase_oe = master_r;
  assign display_blank_n_out = blank_n_out_r;
  assign display_blank_n_oe = master_r;
  assign common_start_pulse_out = start_pulse_out_r;
  assign common_start_pulse_oe = master_r;
  assign static_drive_output_out = static_out_r;
  assign static_drive_output_oe = master_r;
  assign line_clock_seen = pin_r[PIN_LCLK];
  assign ac_phase_seen = pin_r[PIN_AC];
  assign blank_n_seen = pin_r[PIN_BLANK_N];

  sequence s_last_bit;
    ser_done && !core_rst;
  endsequence

  sequence s_word_pushed;
    push_r ##0 (push_word_r[WORD_CLASS_BIT] == $past(is_display));
  endsequence

  property p_select_gates_drive;
    @(posedge clk) disable iff (sys_rst) data_oe_r |-> $past(selected);
  endproperty
  a_select_gates_drive: assert property (p_select_gates_drive) else $error("Bus driven while deselected.");

  property p_8080_drive;
    @(posedge clk) disable iff (core_rst) (mode == MODE_8080 && selected && !pin_r[PIN_RD]) |=> data_oe_r;
  endproperty
  a_8080_drive: assert property (p_8080_drive) else $error("No drive during 8080 read.");

  property p_6800_write;
    @(posedge clk) disable iff (core_rst) wr_6800 |=> push_r && push_word_r[BYTE_W-1:0] == $past(bus_byte);
  endproperty
  a_6800_write: assert property (p_6800_write) else $error("6800 write not captured.");

  property p_serial_no_drive;
    @(posedge clk) disable iff (core_rst) (mode == MODE_SERIAL) [*2] |-> !data_oe_r;
  endproperty
  a_serial_no_drive: assert property (p_serial_no_drive) else $error("Bus driven in serial mode.");

  property p_serial_word;
    @(posedge clk) disable iff (core_rst) s_last_bit |=> s_word_pushed;
  endproperty
  a_serial_word: assert property (p_serial_word) else $error("Serial byte not pushed with class.");

  property p_serial_msb;
    @(posedge clk) disable iff (core_rst) s_last_bit |=> push_word_r[BYTE_W-1:1] == $past(shift_r[BYTE_W-2:0]);
  endproperty
  a_serial_msb: assert property (p_serial_msb) else $error("Serial bit order wrong.");

  property p_deselect_clear;
    @(posedge clk) disable iff (core_rst) !selected |=> bit_cnt_r == BIT_CNT_RST && shift_r == BYTE_RST;
  endproperty
  a_deselect_clear: assert property (p_deselect_clear) else $error("Serial state kept while deselected.");

  property p_role_pins;
    @(posedge clk) disable iff (sys_rst) $past(master_now) == (display_line_clock_oe && display_blank_n_oe &&
                                         common_start_pulse_oe && osc_enable);
  endproperty
  a_role_pins: assert property (p_role_pins) else $error("Pin direction does not follow role.");

  property p_reset_level;
    @(posedge clk) disable iff (sys_rst) !pin_r[PIN_RST_N] [*2] |-> device_init_r && !push_r;
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("Reset level not held.");

endmodule : lhi_host_port

// ---- core/lhi_pkg.sv ----
package lhi_pkg;

  // Width of the host data bus and of one serial word.
  localparam int BYTE_W = 8;
  // Depth of the word buffer between the host port and the core.
  localparam int FIFO_DEPTH = 16;
  // One buffered word is the class bit above the data byte.
  localparam int WORD_W = BYTE_W + 1;
  localparam int WORD_CLASS_BIT = BYTE_W;

  // Bit positions of the pins gathered into one synchroniser bank.
  localparam int PIN_CS_N = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_DC = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_WR = 4;
  localparam int PIN_STYLE = 5;
  localparam int PIN_PS = 6;
  localparam int PIN_MS = 7;
  localparam int PIN_RST_N = 8;
  localparam int PIN_LCLK = 9;
  localparam int PIN_AC = 10;
  localparam int PIN_BLANK_N = 11;
  localparam int PIN_DATA = 12;
  localparam int PIN_W = PIN_DATA + BYTE_W;

  // Data pins reused by the serial link.
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT = 6;

  // Reset values.
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 20'h0_0000;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_8080,
    MODE_6800
  } lhi_mode_e;

endpackage : lhi_pkg

// ---- testbench/lhi_host_model.sv ----
`timescale 1ns/1ns
module lhi_host_model
  import lhi_pkg::*;
(
  input wire logic clk,
  output logic cs_n,
  output logic cs,
  output logic dc,
  output logic rd,
  output logic wr,
  output logic [BYTE_W-1:0] d
);
  initial begin
    {cs_n, cs, dc, rd, wr} = 5'h13;
    d = 8'h00;
  end
  task automatic sel(input logic on);
    @(posedge clk);
    cs_n <= ~on;
    cs <= on;
  endtask : sel
  task automatic idle(input logic m68);
    @(posedge clk);
    rd <= ~m68;
    wr <= 1'b1;
  endtask : idle
  // Serial bits go out MSB first.
  task automatic ser(input logic [7:0] b, input logic c, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge clk);
      d[7] <= b[i];
      d[6] <= 1'b0;
      dc <= (i == 0) ? c : ~c;
      repeat (8) @(posedge clk);
      d[6] <= 1'b1;
      repeat (8) @(posedge clk);
      d[6] <= 1'b0;
    end
    repeat (4) @(posedge clk);
    d[7] <= ~d[7];
  endtask : ser
  // Write pin is strobe or direction.
  task automatic par(input logic [7:0] b, input logic c, input logic m68, input logic rnw);
    @(posedge clk);
    dc <= c;
    if (!rnw) d <= b;
    if (m68) wr <= rnw;
    repeat (4) @(posedge clk);
    if (m68) rd <= 1'b1;
    else if (rnw) rd <= 1'b0;
    else wr <= 1'b0;
    repeat (6) @(posedge clk);
    if (m68) rd <= 1'b0;
    else {rd, wr} <= 2'b11;
    repeat (4) @(posedge clk);
    wr <= 1'b1;
    if (!rnw) d <= ~b;
  endtask : par
endmodule : lhi_host_model

// ---- testbench/lhi_host_port_bench.sv ----
`timescale 1ns/1ns
module lhi_host_port_bench;
  import lhi_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic style = 1'b0;
  logic ps = 1'b1;
  logic ms = 1'b0;
  logic rst_n = 1'b1;
  logic rx_ready = 1'b0;
  logic [2:0] pin_src = 3'h1;
  logic [4:0] tim = 5'h00;
  logic [7:0] rdd = 8'h5a;
  logic [6:0] stat = 7'h33;
  logic cs_n, cs, dc, rd, wr, data_oe, lc_o, lc_oe, ac_o, ac_oe, bl_o, bl_oe, sp_o, sp_oe, sd_o, sd_oe;
  logic lc_s, ac_s, bl_s, osc, pwr, init, rx_valid, rx_disp, read_req, read_disp, busy;
  logic [7:0] hd, data_out, rx_data;
  wire logic [7:0] dpin = data_oe ? data_out : hd;
  int n_fail = 0;
  int checks_done = 0;
  int n_rr = 0;
  int n_oe = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  lhi_host_model i_host (.clk(clk), .cs_n(cs_n), .cs(cs), .dc(dc), .rd(rd), .wr(wr), .d(hd));
  lhi_host_port i_dut (.clk(clk), .sys_rst(sys_rst), .chip_select_low_active_n(cs_n),
    .chip_select_high_active(cs), .data_command_select(dc), .read_strobe_pin(rd), .write_strobe_pin(wr),
    .host_bus_style_select(style), .parallel_serial_select(ps), .master_slave_select(ms),
    .reset_in_n(rst_n), .data_in(dpin), .data_out(data_out), .data_oe(data_oe),
    .display_line_clock_in(lc_oe ? lc_o : pin_src[2]), .display_line_clock_out(lc_o),
    .display_line_clock_oe(lc_oe), .lcd_ac_phase_in(ac_oe ? ac_o : pin_src[1]), .lcd_ac_phase_out(ac_o),
    .lcd_ac_phase_oe(ac_oe), .display_blank_n_in(bl_oe ? bl_o : pin_src[0]), .display_blank_n_out(bl_o),
    .display_blank_n_oe(bl_oe), .common_start_pulse_out(sp_o), .common_start_pulse_oe(sp_oe),
    .static_drive_output_out(sd_o), .static_drive_output_oe(sd_oe), .timing_line_clock(tim[4]),
    .timing_ac_phase(tim[3]), .timing_start_pulse(tim[2]), .timing_static_drive(tim[1]),
    .timing_blank_n(tim[0]), .line_clock_seen(lc_s), .ac_phase_seen(ac_s), .blank_n_seen(bl_s),
    .osc_enable(osc), .power_enable(pwr), .device_init(init), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_is_display(rx_disp), .read_req(read_req), .read_is_display(read_disp),
    .read_display_data(rdd), .read_status(stat), .host_busy(busy));
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(negedge clk) begin
    cyc++;
    if (read_req === 1'b1) n_rr++;
    if (data_oe === 1'b1) n_oe++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : w
  task automatic pop(input logic [7:0] b, input logic c);
    @(negedge clk);
    for (int k = 0; k < 200 && rx_valid !== 1'b1; k++) @(negedge clk);
    chk("rx_word", {rx_disp, rx_data}, {c, b});
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask : pop
  task automatic t_role;
    @(posedge clk);
    ms <= 1'b1;
    tim <= 5'h16;
    w(6);
    chk("master", {2'b00, osc, pwr, lc_oe, ac_oe, bl_oe, sp_oe, sd_oe}, 9'h07f);
    chk("timing", {4'h0, lc_o, ac_o, sp_o, sd_o, bl_o}, {4'h0, 5'h16});
    @(posedge clk);
    ms <= 1'b0;
    pin_src <= 3'h6;
    tim <= 5'h09;
    w(6);
    chk("slave", {2'b00, osc, pwr, lc_oe, ac_oe, bl_oe, sp_oe, sd_oe}, 9'h000);
    chk("seen", {6'h00, lc_s, ac_s, bl_s}, 9'h006);
    chk("timing", {4'h0, lc_o, ac_o, sp_o, sd_o, bl_o}, {4'h0, 5'h09});
    @(posedge clk);
    pin_src <= 3'h1;
    w(4);
    chk("seen", {6'h00, lc_s, ac_s, bl_s}, 9'h001);
  endtask : t_role
  task automatic t_par(input logic m68);
    int rr0;
    int oe0;
    @(posedge clk);
    ps <= 1'b1;
    style <= m68;
    rdd <= ~rdd;
    stat <= ~stat;
    i_host.idle(m68);
    w(6);
    i_host.sel(1'b1);
    i_host.par(8'hc3, 1'b1, m68, 1'b0);
    pop(8'hc3, 1'b1);
    i_host.par(8'h3d, 1'b0, m68, 1'b0);
    pop(8'h3d, 1'b0);
    rr0 = n_rr;
    oe0 = n_oe;
    i_host.par(8'h00, 1'b1, m68, 1'b1);
    w(2);
    chk("read", {1'b0, 4'(n_rr - rr0), 4'(oe0 < n_oe)}, 9'h011);
    chk("rd_data", {read_disp, data_out}, {1'b1, rdd});
    chk("oe_off", {8'h00, data_oe}, 9'h000);
    i_host.par(8'h00, 1'b0, m68, 1'b1);
    w(2);
    chk("status", {read_disp, data_out}, {2'b00, stat});
    i_host.sel(1'b0);
    rr0 = n_rr;
    oe0 = n_oe;
    i_host.par(8'h77, 1'b1, m68, 1'b0);
    i_host.par(8'h00, 1'b1, m68, 1'b1);
    w(8);
    chk("unselected", {rx_valid, 4'(n_rr - rr0), 4'(n_oe - oe0)}, 9'h000);
  endtask : t_par
  task automatic t_fifo;
    i_host.sel(1'b1);
    chk("busy", {8'h00, busy}, 9'h000);
    for (int i = 0; i < FIFO_DEPTH + 2; i++) i_host.par(8'(i), 1'b1, 1'b1, 1'b0);
    w(6);
    chk("busy", {8'h00, busy}, 9'h001);
    for (int i = 0; i <= FIFO_DEPTH; i++) pop(8'(i), 1'b1);
    w(10);
    chk("drained", {7'h00, busy, rx_valid}, 9'h000);
  endtask : t_fifo
  task automatic t_serial;
    int rr0;
    int oe0;
    @(posedge clk);
    ps <= 1'b0;
    i_host.idle(1'b0);
    w(6);
    i_host.ser(8'ha5, 1'b1, 8);
    pop(8'ha5, 1'b1);
    i_host.ser(8'h3c, 1'b0, 8);
    pop(8'h3c, 1'b0);
    i_host.ser(8'hff, 1'b1, 5);
    i_host.sel(1'b0);
    w(4);
    i_host.sel(1'b1);
    i_host.ser(8'h96, 1'b0, 8);
    pop(8'h96, 1'b0);
    rr0 = n_rr;
    oe0 = n_oe;
    i_host.par(8'h00, 1'b1, 1'b0, 1'b1);
    w(8);
    chk("serial_read", {rx_valid, 4'(n_rr - rr0), 4'(n_oe - oe0)}, 9'h000);
  endtask : t_serial
  task automatic t_rst;
    i_host.ser(8'h81, 1'b1, 8);
    w(8);
    chk("pending", {8'h00, rx_valid}, 9'h001);
    @(posedge clk);
    rst_n <= 1'b0;
    w(6);
    chk("init", {7'h00, init, rx_valid}, 9'h002);
    @(posedge clk);
    rst_n <= 1'b1;
    w(8);
    chk("init", {7'h00, init, rx_valid}, 9'h000);
  endtask : t_rst
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    w(4);
    t_role();
    t_par(1'b0);
    t_par(1'b1);
    t_fifo();
    t_serial();
    t_rst();
    summarize();
  end
endmodule : lhi_host_port_bench
